/* verilog/qdscp_pkg.sv */
/*
 Constants shared by the serial command port of the quad DAC: frame layout,
 command and address codes, reset values and output widths.
 Assumes a single 100 MHz core clock domain in the modules that import it.
*/
package qdscp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // channel and code geometry
   localparam int NUM_CH = 4;
   localparam int CH_W = 2;
   localparam int CODE_BITS = 16;
   localparam int SEG_SWITCHES = 15;
   localparam int LADDER_BITS = 12;
   localparam int THERMO_BITS = 4;
   localparam int BUF_W = CH_W + CODE_BITS;
   localparam int BUF_DEPTH = 2;

   ////////////////////////////////////////////////////////////////////////////
   // frame layout, counted from the last bit shifted in
   localparam logic [5:0] FRAME_BITS = 6'h20;
   localparam int CMD_LSB = 24;
   localparam int ADDR_LSB = 20;
   localparam int DATA_MSB = 19;
   localparam int PD_MODE_LSB = 8;
   localparam int CHAIN_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // command codes
   localparam logic [3:0] CMD_WR_INPUT = 4'h0;
   localparam logic [3:0] CMD_UPD_DAC = 4'h1;
   localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WR_UPD = 4'h3;
   localparam logic [3:0] CMD_POWER = 4'h4;
   localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
   localparam logic [3:0] CMD_LOAD_MASK = 4'h6;
   localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
   localparam logic [3:0] CMD_CHAIN = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // address codes and reset values
   localparam logic [3:0] ADDR_ALL = 4'hF;
   localparam logic [15:0] RESET_CODE = 16'h0000;
   localparam logic [15:0] CLEAR_CODE_RST = 16'h0000;
   localparam logic [3:0] LOAD_MASK_RST = 4'h0;
   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic CHAIN_RST = 1'b0;

endpackage

/* verilog/qdscp_buf.sv */
/*
 Small FIFO of DEPTH entries with valid/ready on both sides.
 Assumes one clock; while clk_en is low it neither accepts nor delivers.
*/
`timescale 1ns/10ps
module qdscp_buf #(
   parameter int W = 18,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [CW-1:0] cnt;
   } qdscp_buf_state_type;

   qdscp_buf_state_type st_reg;
   qdscp_buf_state_type st_next;
   logic push;
   logic pop;

   assign in_ready = clk_en && (st_reg.cnt != CW'(DEPTH));
   assign out_valid = clk_en && (st_reg.cnt != '0);
   assign out_data = st_reg.mem[st_reg.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = (st_reg.wr == PW'(DEPTH - 1)) ? '0 : st_reg.wr + PW'(1);
      end
      if (pop) begin
         st_next.rd = (st_reg.rd == PW'(DEPTH - 1)) ? '0 : st_reg.rd + PW'(1);
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + CW'(1);
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - CW'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

endmodule

/* verilog/qdscp_core.sv */
/*
 Serial write port and command decoder of a quad voltage-output DAC.
 Assumes frame select, serial clock, data and load pins come from outside the
 core_clk domain; the serial clock must stay well below core_clk / 4.
*/
`timescale 1ns/10ps
module qdscp_core import qdscp_pkg::*; #(
   parameter int RES_BITS = 16,
   parameter bit CHAIN_CMD_EN = 1'b1
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // serial pins
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic din,
   input wire logic load_strobe_n,
   // register contents
   output logic [NUM_CH-1:0][CODE_BITS-1:0] input_code,
   output logic [NUM_CH-1:0][CODE_BITS-1:0] dac_code,
   output logic [NUM_CH-1:0][1:0] power_mode,
   output logic [CODE_BITS-1:0] clear_code,
   output logic [NUM_CH-1:0] load_mask,
   output logic chain_enable,
   // switch controls
   output logic [NUM_CH-1:0][SEG_SWITCHES-1:0] seg_switch,
   output logic [NUM_CH-1:0][LADDER_BITS-1:0] ladder_switch,
   // frame status
   output logic frame_done,
   output logic frame_reject,
   // update stream
   output logic upd_valid,
   input wire logic upd_ready,
   output logic [CH_W-1:0] upd_channel,
   output logic [CODE_BITS-1:0] upd_code
);

   typedef struct packed {
      logic sclk_m;
      logic sclk_s;
      logic sclk_p;
      logic sync_m;
      logic sync_s;
      logic sync_p;
      logic din_m;
      logic din_s;
      logic ld_m;
      logic ld_s;
      logic in_frame;
      logic [5:0] bit_cnt;
      logic [31:0] shift;
      logic [31:0] frame;
      logic frame_vld;
      logic frame_rej;
      logic [NUM_CH-1:0][CODE_BITS-1:0] inp;
      logic [NUM_CH-1:0][CODE_BITS-1:0] dac;
      logic [NUM_CH-1:0][1:0] pd;
      logic [CODE_BITS-1:0] clear_val;
      logic [NUM_CH-1:0] lmask;
      logic chain;
      logic [NUM_CH-1:0] emit;
      logic [NUM_CH-1:0][SEG_SWITCHES-1:0] seg;
      logic [NUM_CH-1:0][LADDER_BITS-1:0] ladder;
   } qdscp_state_type;

   qdscp_state_type st_reg;
   qdscp_state_type st_next;
   logic fall_w;
   logic sync_fall_w;
   logic sync_rise_w;
   logic [3:0] cmd_w;
   logic [3:0] addr_w;
   logic [CODE_BITS-1:0] code_w;
   logic [NUM_CH-1:0] sel_w;
   logic addr_ok_w;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [BUF_W-1:0] buf_in_data;
   logic [BUF_W-1:0] buf_out_data;
   logic [CH_W-1:0] pick_ch;
   logic found;
   logic [NUM_CH-1:0] pop;
   logic [NUM_CH-1:0] changed;
   logic [CODE_BITS-1:0] lj;

   // codes below 16 bits sit right-aligned; the switch decode wants them left-aligned
   function automatic logic [CODE_BITS-1:0] left_just(input logic [CODE_BITS-1:0] v);
      return v << (CODE_BITS - RES_BITS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // edges seen on the second synchroniser stage only
   assign fall_w = st_reg.sclk_p && !st_reg.sclk_s;
   assign sync_fall_w = st_reg.sync_p && !st_reg.sync_s;
   assign sync_rise_w = !st_reg.sync_p && st_reg.sync_s;
   assign cmd_w = st_reg.frame[CMD_LSB +: 4];
   assign addr_w = st_reg.frame[ADDR_LSB +: 4];
   // data left of the ignored tail
   assign code_w = st_reg.frame[DATA_MSB -: CODE_BITS] >> (CODE_BITS - RES_BITS);

   always_comb begin
      sel_w = '0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         sel_w[ch] = (addr_w == ADDR_ALL) || (addr_w == 4'(ch));
      end
   end
   assign addr_ok_w = |sel_w;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      found = 1'b0;
      pick_ch = '0;
      pop = '0;
      changed = '0;
      lj = '0;
      st_next.sclk_m = sclk;
      st_next.sclk_s = st_reg.sclk_m;
      st_next.sclk_p = st_reg.sclk_s;
      st_next.sync_m = sync_n;
      st_next.sync_s = st_reg.sync_m;
      st_next.sync_p = st_reg.sync_s;
      st_next.din_m = din;
      st_next.din_s = st_reg.din_m;
      st_next.ld_m = load_strobe_n;
      st_next.ld_s = st_reg.ld_m;
      st_next.frame_vld = 1'b0;
      st_next.frame_rej = 1'b0;

      if (sync_fall_w) begin
         st_next.in_frame = 1'b1;
         st_next.bit_cnt = '0;
      end else if (sync_rise_w) begin
         st_next.in_frame = 1'b0;
         if (st_reg.in_frame && st_reg.bit_cnt != FRAME_BITS) begin
            st_next.frame_rej = 1'b1;
         end
      end else if (st_reg.in_frame && !st_reg.sync_s && fall_w) begin
         st_next.shift = {st_reg.shift[30:0], st_reg.din_s};
         // count saturates at one frame; extra edges only shift
         if (st_reg.bit_cnt != FRAME_BITS) begin
            st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
            if (st_reg.bit_cnt == FRAME_BITS - 6'h01) begin
               st_next.frame = {st_reg.shift[30:0], st_reg.din_s};
               st_next.frame_vld = 1'b1;
            end
         end
      end

      if (st_reg.frame_vld) begin
         case (cmd_w)
            CMD_WR_INPUT: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (sel_w[ch]) begin
                     st_next.inp[ch] = code_w;
                  end
               end
            end
            CMD_UPD_DAC: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (sel_w[ch]) begin
                     st_next.dac[ch] = st_reg.inp[ch];
                  end
               end
            end
            CMD_WR_UPD_ALL: begin
               if (addr_ok_w) begin
                  for (int ch = 0; ch < NUM_CH; ch++) begin
                     if (sel_w[ch]) begin
                        st_next.inp[ch] = code_w;
                     end
                  end
                  st_next.dac = st_next.inp;
               end
            end
            CMD_WR_UPD: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (sel_w[ch]) begin
                     st_next.inp[ch] = code_w;
                     st_next.dac[ch] = code_w;
                  end
               end
            end
            CMD_POWER: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (st_reg.frame[ch]) begin
                     st_next.pd[ch] = st_reg.frame[PD_MODE_LSB +: 2];
                  end
               end
            end
            CMD_CLEAR_CODE: begin
               st_next.clear_val = code_w;
            end
            CMD_LOAD_MASK: begin
               st_next.lmask = st_reg.frame[NUM_CH-1:0];
            end
            CMD_SOFT_RESET: begin
               st_next.inp = {NUM_CH{RESET_CODE}};
               st_next.dac = {NUM_CH{RESET_CODE}};
               st_next.pd = {NUM_CH{PD_NORMAL}};
               st_next.clear_val = CLEAR_CODE_RST;
               st_next.lmask = LOAD_MASK_RST;
               st_next.chain = CHAIN_RST;
            end
            CMD_CHAIN: begin
               // only where the variant has it
               if (CHAIN_CMD_EN) begin
                  st_next.chain = st_reg.frame[CHAIN_BIT];
               end
            end
            default: begin
            end
         endcase
      end

      if (!st_reg.ld_s) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (!st_next.lmask[ch]) begin
               st_next.dac[ch] = st_next.inp[ch];
            end
         end
      end

      // one update word per changed channel; a change during a push re-arms it
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (st_reg.emit[ch] && !found) begin
            found = 1'b1;
            pick_ch = CH_W'(ch);
         end
      end
      for (int ch = 0; ch < NUM_CH; ch++) begin
         changed[ch] = st_next.dac[ch] != st_reg.dac[ch];
         pop[ch] = found && buf_in_ready && (pick_ch == CH_W'(ch));
      end
      st_next.emit = (st_reg.emit & ~pop) | changed;

      for (int ch = 0; ch < NUM_CH; ch++) begin
         lj = left_just(st_next.dac[ch]);
         for (int k = 0; k < SEG_SWITCHES; k++) begin
            st_next.seg[ch][k] = k < int'(lj[CODE_BITS-1 -: THERMO_BITS]);
         end
         st_next.ladder[ch] = lj[LADDER_BITS-1:0];
      end
   end

   assign buf_in_valid = found;
   assign buf_in_data = {pick_ch, st_reg.dac[pick_ch]};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver stalls back up into the emit mask, never into the registers
   qdscp_buf #(
      .W(BUF_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(upd_valid),
      .out_ready(upd_ready),
      .out_data(buf_out_data)
   );

   assign upd_channel = buf_out_data[BUF_W-1 -: CH_W];
   assign upd_code = buf_out_data[CODE_BITS-1:0];
   assign input_code = st_reg.inp;
   assign dac_code = st_reg.dac;
   assign power_mode = st_reg.pd;
   assign clear_code = st_reg.clear_val;
   assign load_mask = st_reg.lmask;
   assign chain_enable = st_reg.chain;
   assign seg_switch = st_reg.seg;
   assign ladder_switch = st_reg.ladder;
   assign frame_done = st_reg.frame_vld;
   assign frame_reject = st_reg.frame_rej;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence last_edge_s;
      clk_en && st_reg.in_frame && !st_reg.sync_s && fall_w && !sync_fall_w
         && !sync_rise_w && st_reg.bit_cnt == FRAME_BITS - 6'h01;
   endsequence
   sequence exec_s;
      st_reg.frame_vld && st_reg.bit_cnt == FRAME_BITS;
   endsequence
   sequence early_rise_s;
      clk_en && sync_rise_w && st_reg.in_frame && st_reg.bit_cnt < FRAME_BITS;
   endsequence

   cnt_bound_a: assert property (st_reg.bit_cnt <= FRAME_BITS)
      else $error("bit count beyond one frame");
   shift_cap_a: assert property (clk_en && st_reg.in_frame && !st_reg.sync_s && fall_w
      && !sync_fall_w && !sync_rise_w |=> st_reg.shift[0] == $past(st_reg.din_s))
      else $error("data bit not captured on falling edge");
   frame_exec_a: assert property (last_edge_s |=> exec_s)
      else $error("frame not launched on last edge");
   frame_abort_a: assert property (early_rise_s ##1 st_reg.ld_s |->
      st_reg.frame_rej && !st_reg.frame_vld ##1 ($stable(st_reg.dac) && $stable(st_reg.pd)))
      else $error("short frame changed state");
   input_only_a: assert property (clk_en && st_reg.frame_vld && cmd_w == CMD_WR_INPUT
      && addr_w == 4'h0 && st_reg.ld_s |=> st_reg.inp[0] == $past(code_w)
      && st_reg.dac[0] == $past(st_reg.dac[0]))
      else $error("input write touched DAC register");
   update_all_a: assert property (clk_en && st_reg.frame_vld && cmd_w == CMD_WR_UPD_ALL
      && addr_ok_w |=> st_reg.dac == st_reg.inp)
      else $error("software load missed a channel");
   write_update_a: assert property (clk_en && st_reg.frame_vld && cmd_w == CMD_WR_UPD
      && addr_w == ADDR_ALL |=> st_reg.dac == {NUM_CH{$past(code_w)}})
      else $error("write and update incomplete");
   power_mode_a: assert property (clk_en && st_reg.frame_vld && cmd_w == CMD_POWER
      && st_reg.frame[0] |=> st_reg.pd[0] == $past(st_reg.frame[PD_MODE_LSB +: 2]))
      else $error("power mode not taken");
   soft_reset_a: assert property (clk_en && st_reg.frame_vld && cmd_w == CMD_SOFT_RESET
      |=> st_reg.dac == {NUM_CH{RESET_CODE}} && st_reg.chain == CHAIN_RST
      && st_reg.lmask == LOAD_MASK_RST)
      else $error("software reset incomplete");
   reserved_a: assert property (clk_en && st_reg.frame_vld && cmd_w > CMD_CHAIN
      |=> $stable(st_reg.inp) && $stable(st_reg.pd) && $stable(st_reg.clear_val)
      && $stable(st_reg.lmask) && $stable(st_reg.chain))
      else $error("reserved command acted");
   bad_addr_a: assert property (clk_en && st_reg.frame_vld && cmd_w <= CMD_WR_UPD
      && !addr_ok_w && st_reg.ld_s |=> $stable(st_reg.inp) && $stable(st_reg.dac))
      else $error("undefined address acted");
   chain_set_a: assert property (clk_en && st_reg.frame_vld && cmd_w == CMD_CHAIN
      |=> st_reg.chain == (CHAIN_CMD_EN ? $past(st_reg.frame[CHAIN_BIT]) : $past(st_reg.chain)))
      else $error("chain enable not taken");
   thermo_a: assert property ($countones(st_reg.seg[0])
      == int'(left_just(st_reg.dac[0]) >> LADDER_BITS))
      else $error("segment decode disagrees with code");
   hw_load_a: assert property (clk_en && !st_reg.ld_s && !st_reg.lmask[0]
      && !st_reg.frame_vld |=> st_reg.dac[0] == $past(st_reg.inp[0]))
      else $error("load pin did not update channel");

endmodule

/* verif/qdscp_host.sv */
/*
 Host serial port model: drives frame select, serial clock and data.
 Assumes the core clock is passed in only to pace the pins; sclk period 80 ns.
*/
`timescale 1ns/10ps
module qdscp_host (
   // pacing clock
   input wire logic core_clk,
   // serial pins
   output logic sclk,
   output logic sync_n,
   output logic din
);
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      din = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [31:0] f, input int n);
      @(negedge core_clk);
      sync_n = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
         din = f[31-i];
         repeat (4) @(negedge core_clk);
         sclk = 1'b0;
         repeat (4) @(negedge core_clk);
         sclk = 1'b1;
      end
      repeat (4) @(negedge core_clk);
      sync_n = 1'b1;
      // released line must not look held
      din = ~din;
      repeat (300) @(negedge core_clk);
   endtask
endmodule

/* verif/testbench.sv */
/*
 Self-checking bench for the serial command port: frames, load pin, stream.
 Assumes the host model paces frames; clk_en is tied high.
*/
`timescale 1ns/10ps
module testbench import qdscp_pkg::*;;
   typedef struct {logic [31:0] f; int ch; logic [15:0] ei; logic [15:0] ed;} qdscp_row_type;
   logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, load_strobe_n = 1'b1, upd_ready = 1'b1;
   logic sclk, sync_n, din, frame_done, frame_reject, upd_valid, chain_enable;
   int done_seen = 0, rej_seen = 0, done_base = 0, rej_base = 0;
   logic [NUM_CH-1:0][CODE_BITS-1:0] input_code, dac_code;
   logic [NUM_CH-1:0][1:0] power_mode;
   logic [CODE_BITS-1:0] clear_code, upd_code;
   logic [NUM_CH-1:0] load_mask;
   logic [NUM_CH-1:0][SEG_SWITCHES-1:0] seg_switch;
   logic [NUM_CH-1:0][LADDER_BITS-1:0] ladder_switch;
   logic [CH_W-1:0] upd_channel;
   int errors = 0, num_checks = 0;
   qdscp_row_type rows[8];

   qdscp_host qdscp_host_inst (.core_clk(core_clk), .sclk(sclk), .sync_n(sync_n), .din(din));
   qdscp_core qdscp_core_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .sclk(sclk), .sync_n(sync_n), .din(din), .load_strobe_n(load_strobe_n),
      .input_code(input_code), .dac_code(dac_code), .power_mode(power_mode),
      .clear_code(clear_code), .load_mask(load_mask), .chain_enable(chain_enable),
      .seg_switch(seg_switch), .ladder_switch(ladder_switch), .frame_done(frame_done),
      .frame_reject(frame_reject), .upd_valid(upd_valid), .upd_ready(upd_ready),
      .upd_channel(upd_channel), .upd_code(upd_code));

   always #5 core_clk = ~core_clk;

   // pulses last one cycle, so count them; a double pulse shows up too
   always @(posedge core_clk) begin
      if (frame_done === 1'b1) done_seen <= done_seen + 1;
      if (frame_reject === 1'b1) rej_seen <= rej_seen + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] mkf(logic [3:0] c, logic [3:0] a, logic [15:0] d);
      return {4'hA, c, a, d, 4'h0};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic frame(input logic [31:0] f, input int n);
      @(negedge core_clk);
      done_base = done_seen;
      rej_base = rej_seen;
      qdscp_host_inst.send(f, n);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{mkf(4'h0, 4'h0, 16'h1234), 0, 16'h1234, 16'h0000},
               '{mkf(4'h1, 4'h0, 16'hFFFF), 0, 16'h1234, 16'h1234},
               '{mkf(4'h0, 4'h1, 16'hBEEF), 1, 16'hBEEF, 16'h0000},
               '{mkf(4'h2, 4'h2, 16'h5ABC), 1, 16'hBEEF, 16'hBEEF},
               '{mkf(4'h3, 4'h3, 16'hFFFF), 3, 16'hFFFF, 16'hFFFF},
               '{mkf(4'h3, 4'h5, 16'h0111), 3, 16'hFFFF, 16'hFFFF},
               '{mkf(4'h9, 4'hF, 16'h0000), 3, 16'hFFFF, 16'hFFFF},
               '{mkf(4'h3, 4'hF, 16'h5ABC), 0, 16'h5ABC, 16'h5ABC}};
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      check("dac3", dac_code[3], RESET_CODE);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         frame(rows[i].f, 32);
         check("done", done_seen - done_base, 1);
         check("no reject", rej_seen - rej_base, 0);
         check("input", input_code[rows[i].ch], rows[i].ei);
         check("dac", dac_code[rows[i].ch], rows[i].ed);
      end
      $display("test rows done");
      check("seg", seg_switch[0], 15'h001F);
      check("ladder", ladder_switch[0], 12'hABC);
      frame({4'h0, CMD_POWER, 4'h2, 10'h000, 2'h2, 4'h0, 4'h5}, 32);
      check("power", power_mode, 8'h22);
      frame(mkf(CMD_CLEAR_CODE, 4'h0, 16'hC0DE), 32);
      check("clear", clear_code, 16'hC0DE);
      frame(mkf(CMD_CHAIN, 4'h0, 16'h0000) | 32'h2, 32);
      check("chain", chain_enable, 1'b1);
      $display("test modes done");
      frame(mkf(4'h3, 4'h0, 16'h0001), 20);
      check("reject", rej_seen - rej_base, 1);
      check("no done", done_seen - done_base, 0);
      check("dac0", dac_code[0], 16'h5ABC);
      $display("test abort done");
      frame(mkf(CMD_LOAD_MASK, 4'h0, 16'h0000) | 32'h1, 32);
      frame(mkf(4'h0, 4'hF, 16'h0777), 32);
      check("mask", load_mask, 4'h1);
      load_strobe_n = 1'b0;
      repeat (10) @(negedge core_clk);
      load_strobe_n = 1'b1;
      repeat (5) @(negedge core_clk);
      check("masked", dac_code[0], 16'h5ABC);
      check("loaded", dac_code[3], 16'h0777);
      $display("test load done");
      upd_ready = 1'b0;
      frame(mkf(4'h3, 4'hF, 16'h0999), 32);
      check("stall valid", upd_valid, 1'b1);
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 20 && upd_valid !== 1'b1; k++) @(negedge core_clk);
         check("upd chan", upd_channel, c);
         check("upd code", upd_code, 16'h0999);
         upd_ready = 1'b1;
         @(negedge core_clk);
         upd_ready = 1'b0;
      end
      repeat (5) @(negedge core_clk);
      check("drained", upd_valid, 1'b0);
      upd_ready = 1'b1;
      $display("test stream done");
      frame(mkf(CMD_SOFT_RESET, 4'h0, 16'h0000), 32);
      check("rst dac", dac_code[2], RESET_CODE);
      check("rst power", power_mode, 8'h00);
      check("rst chain", chain_enable, CHAIN_RST);
      check("rst mask", load_mask, LOAD_MASK_RST);
      check("rst clear", clear_code, CLEAR_CODE_RST);
      $display("test soft reset done");
      // pin reset in mid-run, then the port must still take a frame
      frame(mkf(CMD_WR_UPD, 4'hF, 16'h4321), 32);
      check("pre rst dac", dac_code[1], 16'h4321);
      rst_n = 1'b0;
      repeat (10) @(negedge core_clk);
      check("hw rst dac", dac_code[1], RESET_CODE);
      check("hw rst input", input_code[2], RESET_CODE);
      check("hw rst valid", upd_valid, 1'b0);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      frame(mkf(CMD_WR_UPD, 4'h1, 16'h0042), 32);
      check("after rst done", done_seen - done_base, 1);
      check("after rst dac", dac_code[1], 16'h0042);
      check("after rst other", dac_code[0], RESET_CODE);
      $display("test mid reset done");
      close_out();
   end

   // watchdog well beyond the expected length of the run
   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      close_out();
   end
endmodule
